/* hdl/tmr_pkg.sv */
// Package for the 8/16-bit timer/counter block: offsets, fields, resets, types.
// Assumes a 32-bit AXI4-Lite register bus; each register is one aligned word.
package tmr_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [3:0] OFF_COUNT_LOW   = 4'h0;
    localparam logic [3:0] OFF_COUNT_HIGH  = 4'h4;
    localparam logic [3:0] OFF_TIMER_CTRL  = 4'h8;
    localparam logic [3:0] OFF_IRQ_CTRL    = 4'hC;

    // ----------------------------------------
    // Timer control fields
    // ----------------------------------------
    localparam int BIT_RUN_ENABLE      = 7;
    localparam int BIT_EIGHT_BIT       = 6;
    localparam int BIT_CLOCK_SOURCE    = 5;
    localparam int BIT_SOURCE_EDGE     = 4;
    localparam int BIT_PRESCALER_ASSIGN = 3;
    localparam int BIT_RATIO_HI        = 2;

    // ----------------------------------------
    // Interrupt control fields
    // ----------------------------------------
    localparam int BIT_IRQ_ENABLE      = 5;
    localparam int BIT_OVERFLOW_FLAG   = 2;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [7:0] RST_TIMER_CTRL = 8'hFF;
    localparam logic [7:0] RST_COUNT_HIGH = 8'h00;
    localparam logic [7:0] RST_COUNT_LOW  = 8'h00;
    localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic       run_enable;
        logic       eight_bit_select;
        logic       clock_source_select;
        logic       source_edge_select;
        logic       prescaler_assign;
        logic [2:0] prescale_ratio_select;
    } timer_ctrl_t;

    typedef enum logic [1:0] {
        AXI_OKAY   = 2'b00,
        AXI_SLVERR = 2'b10
    } axi_resp_t;

endpackage

/* hdl/edge_sync.sv */
// Two-flop synchroniser with a selectable edge detector behind it.
// Assumes the input is asynchronous to aclk; edges are at most one per two aclk.
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Pin and edge choice
    input  wire logic pin_in,
    input  wire logic falling_sel,
    // Result
    output logic      edge_pulse
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // ----------------------------------------
    // Synchroniser; first flop feeds only the second
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign edge_pulse = falling_sel ? (last_q & ~sync_q) : (~last_q & sync_q);
endmodule // edge_sync
`default_nettype wire

/* hdl/timer_counter.sv */
// Timer/counter with 8-bit prescaler, buffered high byte and overflow interrupt.
// Assumes an AXI4-Lite master on aclk (instruction-cycle clock) and an async count pin.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Clock select clear: count every cycle
// - Low byte write inhibits counting two cycles
// - Clock select set: count pin edges
// - Edge select: clear rising, set falling
// - Count pin synchronised before use
// - Eight-bit prescaler, hidden from software
// - Assigned prescaler divides 1:2 to 1:256
// - Low byte write clears prescaler count while assign bit clear
// - Prescaler settings changeable while running
// - Overflow flag on FF or FFFF wrap
// - Interrupt only while enable bit set
// - Sleep halts the timer completely
// - High byte reached only via buffer
// - Low byte read latches high byte
// - Low byte write loads high byte
module timer_counter (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Device side
    input  wire logic        external_count_input,
    input  wire logic        sleep,
    output logic             irq
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    tmr_pkg::timer_ctrl_t ctrl_q;
    logic [15:0] count_q;
    logic [7:0]  high_buf_q;
    logic [7:0]  presc_q;
    logic [1:0]  inhibit_q;
    logic        overflow_flag_q;
    logic        irq_enable_q;
    logic [7:0]  irq_other_q;
    logic        irq_q;
    logic        sleep_meta_q;
    logic        sleep_q;
    logic        awready_q;
    logic        wready_q;
    logic        arready_q;

    logic        aw_held_q;
    logic [3:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic        wr_go;
    logic        rd_go;
    logic        wr_low;
    logic        wr_high;
    logic        wr_ctrl;
    logic        wr_irq;
    logic        rd_low;
    logic        wr_mapped;
    logic        rd_mapped;
    logic [7:0]  wr_byte;

    assign wr_go   = aw_held_q && w_held_q && !bvalid_q;
    assign rd_go   = s_axi_arvalid && s_axi_arready;
    assign wr_byte = w_data_q[7:0];
    assign wr_mapped = (aw_addr_q[1:0] == 2'b00);
    assign rd_mapped = (s_axi_araddr[1:0] == 2'b00);
    assign wr_low  = wr_go && w_strb_q[0] && wr_mapped && (aw_addr_q == tmr_pkg::OFF_COUNT_LOW);
    assign wr_high = wr_go && w_strb_q[0] && wr_mapped && (aw_addr_q == tmr_pkg::OFF_COUNT_HIGH);
    assign wr_ctrl = wr_go && w_strb_q[0] && wr_mapped && (aw_addr_q == tmr_pkg::OFF_TIMER_CTRL);
    assign wr_irq  = wr_go && w_strb_q[0] && wr_mapped && (aw_addr_q == tmr_pkg::OFF_IRQ_CTRL);
    assign rd_low  = rd_go && rd_mapped && (s_axi_araddr == tmr_pkg::OFF_COUNT_LOW);

    // ----------------------------------------
    // Count source
    // ----------------------------------------
    logic        pin_edge;
    logic        source_tick;
    logic        presc_tick;
    logic        count_tick;
    logic [7:0]  presc_mask;
    logic        wrap;

    edge_sync u_edge_sync (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .pin_in      (external_count_input),
        .falling_sel (ctrl_q.source_edge_select),
        .edge_pulse  (pin_edge)
    );

    // Pin edges or instruction cycles
    assign source_tick = ctrl_q.clock_source_select ? pin_edge : 1'b1;

    // Ratio n gives 2^(n+1); tick when all low n+1 bits are set
    assign presc_mask = 8'hFF >> (3'd7 - ctrl_q.prescale_ratio_select);
    assign presc_tick = ((presc_q & presc_mask) == presc_mask);

    // Sleep and run gate everything; a low byte write masks two cycles
    assign count_tick = ctrl_q.run_enable && !sleep_q && (inhibit_q == 2'd0) && !wr_low
                        && source_tick
                        && (ctrl_q.prescaler_assign || presc_tick);

    assign wrap = ctrl_q.eight_bit_select ? (count_q[7:0] == 8'hFF) : (count_q == 16'hFFFF);

    // ----------------------------------------
    // Sleep input synchroniser
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_meta_q <= 1'b0;
            sleep_q      <= 1'b0;
        end else begin
            sleep_meta_q <= sleep;
            sleep_q      <= sleep_meta_q;
        end
    end

    // ----------------------------------------
    // Prescaler, never visible on the bus
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_q <= 8'h00;
        end else if (wr_low && !ctrl_q.prescaler_assign) begin
            presc_q <= 8'h00;
        end else if (ctrl_q.run_enable && !sleep_q && source_tick && (inhibit_q == 2'd0)) begin
            presc_q <= presc_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Post-write inhibit
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inhibit_q <= 2'd0;
        end else if (wr_low) begin
            inhibit_q <= tmr_pkg::WRITE_INHIBIT_CYCLES;
        end else if (inhibit_q != 2'd0) begin
            inhibit_q <= inhibit_q - 2'd1;
        end
    end

    // ----------------------------------------
    // Counter and high byte buffer
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= {tmr_pkg::RST_COUNT_HIGH, tmr_pkg::RST_COUNT_LOW};
        end else if (wr_low) begin
            count_q <= {high_buf_q, wr_byte};
        end else if (count_tick) begin
            if (ctrl_q.eight_bit_select) begin
                count_q[7:0] <= count_q[7:0] + 8'h01;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // True high byte only moves through this buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_buf_q <= tmr_pkg::RST_COUNT_HIGH;
        end else if (rd_low) begin
            high_buf_q <= count_q[15:8];
        end else if (wr_high) begin
            high_buf_q <= wr_byte;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= tmr_pkg::RST_TIMER_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= wr_byte;
        end
    end

    // ----------------------------------------
    // Interrupt: set wins over a clearing write
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_q <= 1'b0;
            irq_enable_q    <= 1'b0;
            irq_other_q     <= 8'h00;
        end else begin
            if (count_tick && wrap) begin
                overflow_flag_q <= 1'b1;
            end else if (wr_irq && wr_byte[tmr_pkg::BIT_OVERFLOW_FLAG]) begin
                overflow_flag_q <= 1'b0;
            end
            if (wr_irq) begin
                irq_enable_q <= wr_byte[tmr_pkg::BIT_IRQ_ENABLE];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= overflow_flag_q && irq_enable_q;
        end
    end

    // ----------------------------------------
    // AXI write channel
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= tmr_pkg::AXI_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? tmr_pkg::AXI_OKAY : tmr_pkg::AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Readies mirror the held flags from flops, so no bus output is combinational
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awready_q <= 1'b0;
            end else if (wr_go) begin
                awready_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wready_q <= 1'b0;
            end else if (wr_go) begin
                wready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            tmr_pkg::OFF_COUNT_LOW:  rd_byte = count_q[7:0];
            tmr_pkg::OFF_COUNT_HIGH: rd_byte = high_buf_q;
            tmr_pkg::OFF_TIMER_CTRL: rd_byte = ctrl_q;
            tmr_pkg::OFF_IRQ_CTRL:   rd_byte = {2'b00, irq_enable_q, 2'b00, overflow_flag_q, 2'b00};
            default:                 rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= tmr_pkg::AXI_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_mapped ? tmr_pkg::AXI_OKAY : tmr_pkg::AXI_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Refuse a new address while read data is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
        end else if (rd_go) begin
            arready_q <= 1'b0;
        end else if (s_axi_rready) begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign irq           = irq_q;

endmodule // timer_counter
`default_nettype wire

/* sim/tmr_monitor.sv */
// Checker for the timer/counter: register bus handshakes, irq and sleep.
// Assumes it is bound to timer_counter and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module tmr_monitor (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Register bus
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Device side
    input  wire logic        sleep,
    input  wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Six cycles covers the sleep synchroniser and the irq register
    sequence asleep_quiet;
        (sleep && !s_axi_bvalid)[*6];
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    reset_idle_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready
        && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("bus or irq not idle after reset");
    write_latency_a: assert property (both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after address and data");
    write_okay_a: assert property (both_taken ##0 s_axi_awaddr[1:0] == 2'b00
        |-> ##2 s_axi_bresp == tmr_pkg::AXI_OKAY)
        else $error("aligned write not answered okay");
    write_error_a: assert property (both_taken ##0 s_axi_awaddr[1:0] != 2'b00
        |-> ##2 s_axi_bresp == tmr_pkg::AXI_SLVERR)
        else $error("unaligned write not refused");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before taken");
    read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    sleep_irq_a: assert property (asleep_quiet |=> !$rose(irq))
        else $error("irq rose while asleep");
endmodule // tmr_monitor
`default_nettype wire

/* sim/pin_source.sv */
// Count pin model: an external event source driving bursts of pulses.
// Assumes the bench calls pulses() or step(); the pin rests at its last level.
`timescale 1ns/10ps
`default_nettype none
module pin_source (
    // Count pin
    output logic pin
);
    initial pin = 1'b0;
    // Each level held 350 ns, over three aclk periods, so the
    // synchroniser never misses an edge
    task automatic pulses(input int n);
        repeat (n) begin
            #350 pin = 1'b1;
            #350 pin = 1'b0;
        end
    endtask
    // Single level change, so a burst can end high
    task automatic step(input logic lv);
        #350 pin = lv;
    endtask
endmodule // pin_source
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the timer/counter: registers, modes, prescaler, irq.
// Assumes the design, its checker and the count pin model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [3:0] A_LO = tmr_pkg::OFF_COUNT_LOW;
    localparam logic [3:0] A_HI = tmr_pkg::OFF_COUNT_HIGH;
    localparam logic [3:0] A_CTL = tmr_pkg::OFF_TIMER_CTRL;
    localparam logic [3:0] A_IRQ = tmr_pkg::OFF_IRQ_CTRL;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        external_count_input;
    logic        sleep = 1'b0;
    logic        irq;
    logic [7:0]  v;
    logic [7:0]  w;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cycles = 0;

    timer_counter u_timer_counter (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .external_count_input, .sleep, .irq);
    pin_source u_pin_source (.pin(external_count_input));

    always #50 aclk = ~aclk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic finish_test;
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Full run is near 3k cycles; ceiling leaves wide margin
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({6'h00, s_axi_bresp}, {6'h00, er});
    endtask

    // Ready raised only after data shows, so the hold rule is exercised
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        d = s_axi_rdata[7:0];
        chk({6'h00, s_axi_rresp}, (a[1:0] == 2'b00) ? 8'h00 : 8'h02);
        s_axi_rready <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(A_CTL, v);
        chk(v, 8'hFF);
        rd(A_HI, v);
        chk(v, 8'h00);
        rd(A_IRQ, v);
        chk(v, 8'h00);
        rd(A_LO, v);
        chk(v, 8'h00);
        rd(4'h6, v);
        chk(v, 8'h00);
        wr(4'h2, 8'h00, 2'b10);
        chk({7'h00, irq}, 8'h00);
    endtask

    task automatic t_timer;
        wr(A_CTL, 8'h88, 2'b00);
        wr(A_HI, 8'hAB, 2'b00);
        wr(A_LO, 8'hFD, 2'b00);
        rd(A_LO, v);
        chk(v, 8'hFD);
        rd(A_LO, v);
        chk(v, 8'h01);
        rd(A_HI, v);
        chk(v, 8'hAC);
    endtask

    task automatic t_overflow;
        wr(A_HI, 8'hFF, 2'b00);
        wr(A_LO, 8'hFE, 2'b00);
        repeat (4) @(posedge aclk);
        rd(A_IRQ, v);
        chk(v, 8'h04);
        chk({7'h00, irq}, 8'h00);
        wr(A_IRQ, 8'h20, 2'b00);
        @(posedge aclk);
        chk({7'h00, irq}, 8'h01);
        wr(A_IRQ, 8'h24, 2'b00);
        @(posedge aclk);
        chk({7'h00, irq}, 8'h00);
        rd(A_IRQ, v);
        chk(v, 8'h20);
    endtask

    // High byte not FF, so only an eight-bit wrap can set the flag
    task automatic t_eight;
        wr(A_CTL, 8'hC8, 2'b00);
        wr(A_HI, 8'h12, 2'b00);
        wr(A_LO, 8'hFE, 2'b00);
        repeat (4) @(posedge aclk);
        rd(A_IRQ, v);
        chk(v, 8'h24);
        rd(A_LO, v);
        rd(A_HI, v);
        chk(v, 8'h12);
        wr(A_IRQ, 8'h04, 2'b00);
        wr(A_CTL, 8'h48, 2'b00);
        wr(A_LO, 8'h5A, 2'b00);
        repeat (10) @(posedge aclk);
        rd(A_LO, v);
        chk(v, 8'h5A);
    endtask

    // Read lands mid-period after four prescaled ticks, three at ratio 0
    task automatic t_prescale;
        for (int r = 0; r < 8; r++) begin
            wr(A_CTL, 8'h80 | 8'(r), 2'b00);
            wr(A_LO, 8'h00, 2'b00);
            repeat (9 * (1 << r) - 2) @(posedge aclk);
            rd(A_LO, v);
            chk(v, (r == 0) ? 8'h03 : 8'h04);
        end
    endtask

    // Bursts are lopsided, so rising and falling counts differ by one
    task automatic t_counter;
        wr(A_CTL, 8'hE8, 2'b00);
        wr(A_LO, 8'h00, 2'b00);
        u_pin_source.pulses(4);
        u_pin_source.step(1'b1);
        repeat (6) @(posedge aclk);
        rd(A_LO, v);
        chk(v, 8'h05);
        wr(A_CTL, 8'hF8, 2'b00);
        wr(A_LO, 8'h00, 2'b00);
        u_pin_source.step(1'b0);
        u_pin_source.pulses(2);
        repeat (6) @(posedge aclk);
        rd(A_LO, v);
        chk(v, 8'h03);
    endtask

    // Wrap would fall inside the sleep if the timer kept running
    task automatic t_sleep;
        wr(A_IRQ, 8'h24, 2'b00);
        wr(A_CTL, 8'hC8, 2'b00);
        wr(A_LO, 8'hF0, 2'b00);
        sleep <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(A_LO, v);
        repeat (20) @(posedge aclk);
        rd(A_LO, w);
        chk(w, v);
        rd(A_IRQ, w);
        chk(w, 8'h20);
        chk({7'h00, irq}, 8'h00);
        sleep <= 1'b0;
    endtask

    // Timer resumes and wraps, then a mid-run reset must restore power-up state
    task automatic t_restart;
        repeat (20) @(posedge aclk);
        chk({7'h00, irq}, 8'h01);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
    endtask
    // ----------------------------------------
    // Run
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_timer;
        t_overflow;
        t_eight;
        t_prescale;
        t_counter;
        t_sleep;
        t_restart;
        finish_test;
    end
endmodule // testbench

bind timer_counter tmr_monitor u_tmr_monitor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sleep, .irq);
`default_nettype wire
